//--- serial_write_cfg.svh
// Notes on behaviour
// - Function 10h writes consecutive registers from a 16-bit start address, upper byte first.
// - A 16-bit register count, upper byte first, sets exactly how many registers are written.
// - The byte count after the register count equals twice that count and sizes the data.
// - Each 16-bit value travels upper byte first, then lower byte.
// - A 32-bit data item spans two registers, upper half at the even address.
// - Every frame ends with CRC-16, lower byte first, over all preceding bytes.
// - A good function 06h write is answered by an exact echo of the query.
// - No reply begins before the frame gap and the reply wait setting have passed.
// - A start command reaches the motor within the frame gap plus 2 ms.
// - Stop or speed replies wait processing time, frame gap and reply wait setting.
// - Stop or speed actions reach the motor within processing time, frame gap and 2 ms.
// - Clearing run/hold with brake release still set ramps the motor down.
// - Clearing brake release stops the motor at once, with no ramp.
// - A rotation speed of zero decelerates the motor even while run/hold is on.
// - With immediate update selected a new speed acts on the running motor at once.
// - Remote input writes act identically at the direct and the indirect address.
// - Remote bits 0-2 select data, bit3 run, bit4 brake, bit5 direction, bit7 clear.
`ifndef SERIAL_WRITE_CFG_SVH
`define SERIAL_WRITE_CFG_SVH

// Register map of the bus slave, byte addresses.
`define REG_CTRL 8'h00
`define REG_TIMING 8'h04
`define REG_STATUS 8'h08
`define REG_SPEED 8'h0C

// Reset values: slave address 1 with immediate update, 1144-cycle character, no reply wait.
`define CTRL_RESET 32'h0000_0101
`define TIMING_RESET 32'h0000_0478
`define CTRL_IMM_BIT 8

// Function codes.
`define FC_WRITE_ONE 8'h06
`define FC_WRITE_MANY 8'h10

// Holding register addresses.
`define ADDR_OPDATA_BASE 16'h1340
`define ADDR_REMOTE_DIRECT_HI 16'h007C
`define ADDR_REMOTE_DIRECT_LO 16'h007D
`define OPDATA_ITEMS 5
`define ITEM_SPEED 0
`define ITEM_TORQUE 1
`define ITEM_ACCEL 2
`define ITEM_DECEL 3
`define ITEM_REMOTE 4

// Default remote input bit functions.
`define BIT_SEL_LSB 0
`define BIT_RUN 3
`define BIT_BRAKE 4
`define BIT_DIR 5
`define BIT_CLEAR 7

// Frame checking.
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define FRAME_MAX 9'h100
`define ONE_WRITE_LEN 9'h008
`define MANY_OVERHEAD 9'h009
`define MANY_DATA_START 8'h07
`define REPLY_LAST 3'h7
`define REPLY_CRC_FIRST 3'h6

// Timing.
`define CLK_PERIOD_NS 10
`define MS_TIME_NS 1000000
`define MS_CYCLES (`MS_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- serial_write_pkg.sv
package serial_write_pkg;

    // Frame handler states, one-hot.
    typedef enum logic [5:0] {
        ST_RX = 6'b000001,
        ST_PARSE = 6'b000010,
        ST_WAIT = 6'b000100,
        ST_SEND_RD = 6'b001000,
        ST_SEND_LD = 6'b010000,
        ST_SEND_HS = 6'b100000
    } frame_state_type;

    // One byte of the serial link with its qualifier.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_stream_type;

    // Command set presented to the motor drive.
    typedef struct packed {
        logic run;
        logic brakeStop;
        logic direction;
        logic [2:0] dataSelect;
        logic faultClear;
        logic [31:0] speed;
        logic [31:0] torqueLimit;
        logic [31:0] accelTime;
        logic [31:0] decelTime;
    } motor_cmd_type;

endpackage : serial_write_pkg

//--- frame_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module frame_buffer (
    // Clock.
    input wire logic clk,
    // Write port.
    input wire logic writeEn,
    input wire logic [7:0] writeAddr,
    input wire logic [7:0] writeData,
    // Read port, data one cycle after the address.
    input wire logic [7:0] readAddr,
    output logic [7:0] readData_r
);

    logic [7:0] mem [0:255];

    // The array has no reset, so read data are only trusted where written first.
    always_ff @(posedge clk) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
        readData_r <= mem[readAddr];
    end

endmodule : frame_buffer
`default_nettype wire

//--- serial_register_write_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "serial_write_cfg.svh"
module serial_register_write_slave #(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial byte link.
    input wire serial_write_pkg::byte_stream_type rxIn,
    output serial_write_pkg::byte_stream_type txOut,
    input wire logic txReady,
    // Motor command.
    output serial_write_pkg::motor_cmd_type motorCmd
);
    import serial_write_pkg::*;

    frame_state_type state_r;
    logic [31:0] ctrl_r, timing_r;
    logic ahbWrPend_r;
    logic [7:0] ahbAddr_r;
    logic [8:0] rxCount_r;
    logic [15:0] rxCrc_r, txCrc_r;
    logic [18:0] idleCnt_r, gapCycles;
    logic overflow_r, frameEnd, accept, lenOk;
    logic [7:0] hdrAddr_r, hdrFc_r, hdrBytes_r, hiByte_r;
    logic [15:0] hdrStart_r, hdrCount_r, wordIdx_r, waitCnt_r;
    logic [7:0] rdAddr_r, rdData, rdLeft_r;
    logic rdVal_r, byteSel_r;
    logic [2:0] txIdx_r;
    logic [31:0] msCnt_r;
    logic msTick;
    logic regWe;
    logic [15:0] regAddr, regData;
    logic [31:0] opData_r [0:`OPDATA_ITEMS-1];
    logic [31:0] appliedSpeed_r;
    logic prevRun_r, prevClear_r;
    logic [31:0] hrdata_r;
    byte_stream_type txOut_r;
    motor_cmd_type motorCmd_r;

    // Byte-wise reflected CRC-16; a frame whose trailer is correct leaves zero.
    function automatic logic [15:0] crcByte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crcByte

    // Address phase is registered; the slave never inserts wait states.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ahbWrPend_r <= 1'b0;
            ahbAddr_r <= 8'h00;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ahbWrPend_r <= hsel && hready && htrans[1] && hwrite && (hsize == 3'h2);
            if (hsel && hready && htrans[1]) begin
                ahbAddr_r <= haddr[7:0];
            end
        end
    end

    // Writes land in the data phase; unmapped or read-only offsets ignore them.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `CTRL_RESET;
            timing_r <= `TIMING_RESET;
        end else if (ahbWrPend_r) begin
            if (ahbAddr_r == `REG_CTRL) begin
                ctrl_r <= {23'h00_0000, hwdata[8:0]};
            end else if (ahbAddr_r == `REG_TIMING) begin
                timing_r <= hwdata;
            end
        end
    end

    // Read data are prepared in the address phase so they stand through the data phase.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata_r <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            if (haddr[7:0] == `REG_CTRL) begin
                hrdata_r <= ctrl_r;
            end else if (haddr[7:0] == `REG_TIMING) begin
                hrdata_r <= timing_r;
            end else if (haddr[7:0] == `REG_STATUS) begin
                hrdata_r <= {19'h0_0000, state_r, 1'b0, motorCmd_r.dataSelect,
                    motorCmd_r.direction, motorCmd_r.brakeStop, motorCmd_r.run};
            end else if (haddr[7:0] == `REG_SPEED) begin
                hrdata_r <= appliedSpeed_r;
            end else begin
                hrdata_r <= 32'h0000_0000;
            end
        end
    end
    assign hrdata = hrdata_r;

    // Gap of 3.5 characters, rounded up, from the programmed character time.
    assign gapCycles = 19'((19'(timing_r[15:0]) * 19'h0_0007 + 19'h0_0001) >> 1);
    assign frameEnd = (state_r == ST_RX) && (rxCount_r != 9'h000) && !rxIn.valid
        && (idleCnt_r >= gapCycles);

    // Length check for both write kinds; count and byte-count consistency for multiple writes only.
    assign lenOk = (hdrFc_r == `FC_WRITE_ONE) ? (rxCount_r == `ONE_WRITE_LEN)
        : (hdrFc_r == `FC_WRITE_MANY) && (hdrCount_r != 16'h0000) && !hdrCount_r[15]
        && ({8'h00, hdrBytes_r} == {hdrCount_r[14:0], 1'b0})
        && (rxCount_r == {1'b0, hdrBytes_r} + `MANY_OVERHEAD);
    assign accept = (hdrAddr_r == ctrl_r[7:0]) && (rxCrc_r == 16'h0000) && !overflow_r
        && lenOk;

    // Silence counter; saturates so a long idle link never wraps into a false frame.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            idleCnt_r <= 19'h0_0000;
        end else if (rxIn.valid) begin
            idleCnt_r <= 19'h0_0000;
        end else if (idleCnt_r != 19'h7_FFFF) begin
            idleCnt_r <= idleCnt_r + 19'h0_0001;
        end
    end

    // Reception: bytes go to the buffer, CRC runs, header fields are captured in place.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rxCount_r <= 9'h000;
            rxCrc_r <= `CRC_INIT;
            overflow_r <= 1'b0;
            hdrAddr_r <= 8'h00;
            hdrFc_r <= 8'h00;
            hdrStart_r <= 16'h0000;
            hdrCount_r <= 16'h0000;
            hdrBytes_r <= 8'h00;
        end else if (state_r != ST_RX || frameEnd) begin
            rxCount_r <= 9'h000;
            rxCrc_r <= `CRC_INIT;
            overflow_r <= 1'b0;
        end else if (rxIn.valid) begin
            if (rxCount_r == `FRAME_MAX) begin
                overflow_r <= 1'b1;
            end else begin
                rxCount_r <= rxCount_r + 9'h001;
                rxCrc_r <= crcByte(rxCrc_r, rxIn.data);
            end
            // Sixteen-bit fields arrive upper byte first.
            case (rxCount_r)
                9'h000: hdrAddr_r <= rxIn.data;
                9'h001: hdrFc_r <= rxIn.data;
                9'h002: hdrStart_r[15:8] <= rxIn.data;
                9'h003: hdrStart_r[7:0] <= rxIn.data;
                9'h004: hdrCount_r[15:8] <= rxIn.data;
                9'h005: hdrCount_r[7:0] <= rxIn.data;
                9'h006: hdrBytes_r <= rxIn.data;
                default: ;
            endcase
        end
    end

    frame_buffer buffer (
        .clk(core_clk),
        .writeEn(state_r == ST_RX && rxIn.valid && rxCount_r != `FRAME_MAX),
        .writeAddr(rxCount_r[7:0]),
        .writeData(rxIn.data),
        .readAddr(rdAddr_r),
        .readData_r(rdData)
    );

    // Millisecond enable, restarted on entry to the wait so each wait is whole.
    assign msTick = (msCnt_r == 32'(MS_CYCLES - 1));
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            msCnt_r <= 32'h0000_0000;
        end else if (state_r != ST_WAIT || msTick) begin
            msCnt_r <= 32'h0000_0000;
        end else begin
            msCnt_r <= msCnt_r + 32'h0000_0001;
        end
    end

    // One register write port; single writes apply at frame end, multiple during replay.
    always_comb begin
        regWe = 1'b0;
        regAddr = hdrStart_r;
        regData = hdrCount_r;
        if (frameEnd && accept && hdrFc_r == `FC_WRITE_ONE) begin
            regWe = 1'b1;
        end else if (state_r == ST_PARSE && rdVal_r && byteSel_r) begin
            regWe = 1'b1;
            regAddr = hdrStart_r + wordIdx_r;
            regData = {hiByte_r, rdData};
        end
    end

    // Frame sequencing: check, replay data, wait, then send the reply.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_RX;
            rdAddr_r <= 8'h00;
            rdLeft_r <= 8'h00;
            rdVal_r <= 1'b0;
            byteSel_r <= 1'b0;
            hiByte_r <= 8'h00;
            wordIdx_r <= 16'h0000;
            waitCnt_r <= 16'h0000;
            txIdx_r <= 3'h0;
            txCrc_r <= `CRC_INIT;
            txOut_r <= '0;
        end else begin
            case (state_r)
                ST_RX: begin
                    // The gap has already passed here; the reply wait is added next.
                    if (frameEnd && accept) begin
                        waitCnt_r <= timing_r[31:16];
                        rdAddr_r <= `MANY_DATA_START;
                        rdLeft_r <= hdrBytes_r;
                        wordIdx_r <= 16'h0000;
                        byteSel_r <= 1'b0;
                        state_r <= (hdrFc_r == `FC_WRITE_MANY) ? ST_PARSE : ST_WAIT;
                    end
                end
                ST_PARSE: begin
                    // Exactly the counted bytes are replayed, paired upper then lower.
                    rdVal_r <= (rdLeft_r != 8'h00);
                    if (rdLeft_r != 8'h00) begin
                        rdAddr_r <= rdAddr_r + 8'h01;
                        rdLeft_r <= rdLeft_r - 8'h01;
                    end
                    if (rdVal_r) begin
                        byteSel_r <= !byteSel_r;
                        if (!byteSel_r) begin
                            hiByte_r <= rdData;
                        end else begin
                            wordIdx_r <= wordIdx_r + 16'h0001;
                        end
                    end
                    if (rdLeft_r == 8'h00 && !rdVal_r) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (waitCnt_r == 16'h0000) begin
                        rdAddr_r <= 8'h00;
                        txIdx_r <= 3'h0;
                        txCrc_r <= `CRC_INIT;
                        state_r <= ST_SEND_RD;
                    end else if (msTick) begin
                        waitCnt_r <= waitCnt_r - 16'h0001;
                    end
                end
                ST_SEND_RD: begin
                    state_r <= ST_SEND_LD;
                end
                ST_SEND_LD: begin
                    // Single writes echo all eight stored bytes; multiple writes get fresh CRC.
                    txOut_r.valid <= 1'b1;
                    if (hdrFc_r == `FC_WRITE_MANY && txIdx_r == `REPLY_CRC_FIRST) begin
                        txOut_r.data <= txCrc_r[7:0];
                    end else if (hdrFc_r == `FC_WRITE_MANY && txIdx_r == `REPLY_LAST) begin
                        txOut_r.data <= txCrc_r[15:8];
                    end else begin
                        txOut_r.data <= rdData;
                    end
                    state_r <= ST_SEND_HS;
                end
                ST_SEND_HS: begin
                    if (txReady) begin
                        txOut_r.valid <= 1'b0;
                        // The trailer covers the six header bytes only, never its own low byte.
                        if (txIdx_r < `REPLY_CRC_FIRST) begin
                            txCrc_r <= crcByte(txCrc_r, txOut_r.data);
                        end
                        txIdx_r <= txIdx_r + 3'h1;
                        rdAddr_r <= {5'h00, txIdx_r + 3'h1};
                        state_r <= (txIdx_r == `REPLY_LAST) ? ST_RX : ST_SEND_RD;
                    end
                end
                default: state_r <= ST_RX;
            endcase
        end
    end
    assign txOut = txOut_r;

    // Holding registers: one 32-bit item per pair, upper half at the even address.
    for (genvar i = 0; i < `OPDATA_ITEMS; i++) begin : gItem
        localparam logic [15:0] HI_ADDR = `ADDR_OPDATA_BASE + 16'(2 * i);
        localparam logic [15:0] LO_ADDR = HI_ADDR + 16'h0001;
        localparam bit IS_REMOTE = (i == `ITEM_REMOTE);
        always_ff @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                opData_r[i] <= 32'h0000_0000;
            end else if (regWe) begin
                // Remote input also answers at its direct address, with identical effect.
                if (regAddr == HI_ADDR || (IS_REMOTE && regAddr == `ADDR_REMOTE_DIRECT_HI)) begin
                    opData_r[i][31:16] <= regData;
                end else if (regAddr == LO_ADDR
                    || (IS_REMOTE && regAddr == `ADDR_REMOTE_DIRECT_LO)) begin
                    opData_r[i][15:0] <= regData;
                end
            end
        end
    end

    // Speed takes effect at once when immediate, else when run/hold next turns on.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            appliedSpeed_r <= 32'h0000_0000;
            prevRun_r <= 1'b0;
            prevClear_r <= 1'b0;
        end else begin
            prevRun_r <= opData_r[`ITEM_REMOTE][`BIT_RUN];
            prevClear_r <= opData_r[`ITEM_REMOTE][`BIT_CLEAR];
            if (ctrl_r[`CTRL_IMM_BIT] || (opData_r[`ITEM_REMOTE][`BIT_RUN] && !prevRun_r)) begin
                appliedSpeed_r <= opData_r[`ITEM_SPEED];
            end
        end
    end

    // Drive outputs follow register writes within three cycles (speed only when immediate, run via the applied speed), far inside 2 ms.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            motorCmd_r <= '0;
        end else begin
            // Run needs run/hold, brake release and non-zero speed; losing any but brake ramps.
            motorCmd_r.run <= opData_r[`ITEM_REMOTE][`BIT_RUN]
                && opData_r[`ITEM_REMOTE][`BIT_BRAKE]
                && (appliedSpeed_r != 32'h0000_0000);
            motorCmd_r.brakeStop <= !opData_r[`ITEM_REMOTE][`BIT_BRAKE];
            motorCmd_r.direction <= opData_r[`ITEM_REMOTE][`BIT_DIR];
            motorCmd_r.dataSelect <= opData_r[`ITEM_REMOTE][`BIT_SEL_LSB +: 3];
            motorCmd_r.faultClear <= opData_r[`ITEM_REMOTE][`BIT_CLEAR] && !prevClear_r;
            motorCmd_r.speed <= appliedSpeed_r;
            motorCmd_r.torqueLimit <= opData_r[`ITEM_TORQUE];
            motorCmd_r.accelTime <= opData_r[`ITEM_ACCEL];
            motorCmd_r.decelTime <= opData_r[`ITEM_DECEL];
        end
    end
    assign motorCmd = motorCmd_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    chk_gap_ends_frame: assert property (frameEnd
        |-> idleCnt_r >= gapCycles && !rxIn.valid)
        else $error("Frame ended before the silent gap.");
    chk_bad_crc_drop: assert property (frameEnd && rxCrc_r != 16'h0000
        |=> state_r == ST_RX)
        else $error("Frame with bad CRC was accepted.");
    chk_no_early_reply: assert property (state_r == ST_WAIT |-> !txOut_r.valid)
        else $error("Reply started during the wait.");
    chk_zero_wait_send: assert property ($rose(state_r == ST_WAIT) && waitCnt_r == 16'h0000
        |=> state_r == ST_SEND_RD)
        else $error("Reply did not follow a zero wait.");
    chk_brake_instant: assert property (regWe && regAddr == `ADDR_REMOTE_DIRECT_LO
        && !regData[`BIT_BRAKE] |-> ##2 motorCmd_r.brakeStop && !motorCmd_r.run)
        else $error("Brake release clear did not stop at once.");
    chk_run_clear_ramp: assert property (regWe && regAddr == `ADDR_OPDATA_BASE + 16'h0009
        && !regData[`BIT_RUN] && regData[`BIT_BRAKE]
        |-> ##2 !motorCmd_r.run && !motorCmd_r.brakeStop)
        else $error("Run clear did not ramp down.");
    chk_zero_speed_stop: assert property (appliedSpeed_r == 32'h0000_0000
        |=> !motorCmd_r.run)
        else $error("Motor runs at zero speed.");
    chk_speed_immediate: assert property (regWe && regAddr == `ADDR_OPDATA_BASE + 16'h0001
        && ctrl_r[`CTRL_IMM_BIT] |-> ##2 appliedSpeed_r[15:0] == $past(regData, 2))
        else $error("Immediate speed was not applied.");
    chk_crc_trailer: assert property (state_r == ST_SEND_HS && hdrFc_r == `FC_WRITE_MANY
        && txIdx_r == `REPLY_CRC_FIRST |-> txOut_r.data == txCrc_r[7:0])
        else $error("Reply CRC low byte is wrong.");
    chk_clear_pulse: assert property (motorCmd_r.faultClear |=> !motorCmd_r.faultClear)
        else $error("Fault clear is not a pulse.");

    cov_single_reply: cover property (state_r == ST_SEND_HS && txReady
        && txIdx_r == `REPLY_LAST && hdrFc_r == `FC_WRITE_ONE);
    cov_multi_reply: cover property (state_r == ST_SEND_HS && txReady
        && txIdx_r == `REPLY_LAST && hdrFc_r == `FC_WRITE_MANY);
    cov_motor_runs: cover property ($rose(motorCmd_r.run));
    cov_brake_stop: cover property (motorCmd_r.run ##1 motorCmd_r.brakeStop);

endmodule : serial_register_write_slave
`default_nettype wire

//--- serial_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module serial_master_model (
    // Clock.
    input wire logic core_clk,
    // Byte link towards the slave.
    output serial_write_pkg::byte_stream_type rxIn,
    input wire serial_write_pkg::byte_stream_type txOut,
    output logic txReady
);
    import serial_write_pkg::*;
    logic [7:0] replyQ[$];
    logic [1:0] slow = 2'h0;
    initial rxIn = '0;
    // A slow taker: one reply byte every fourth cycle at the most.
    always @(posedge core_clk) begin
        slow <= slow + 2'h1;
        txReady <= (slow == 2'h3);
        if (txOut.valid && txReady)
            replyQ.push_back(txOut.data);
    end
    // Bytes go two cycles apart, well inside the gap, and idle data is inverted.
    task automatic sendFrame(input logic [7:0] q[$]);
        foreach (q[i]) begin
            @(posedge core_clk) rxIn <= '{1'b1, q[i]};
            @(posedge core_clk) rxIn <= '{1'b0, ~q[i]};
        end
    endtask : sendFrame
endmodule : serial_master_model
`default_nettype wire

//--- serial_register_write_slave_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module serial_register_write_slave_tb_top;
    import serial_write_pkg::*;
    typedef struct {int len; logic [215:0] p; logic [5:0] rbd; logic [31:0] spd;} row_type;
    logic core_clk, reset_n, hsel, hwrite, hready, hreadyout, hresp, txReady;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] c;
    logic [7:0] q[$];
    byte_stream_type rxIn, txOut;
    motor_cmd_type motorCmd;
    int fail_count, tests_run, cyc, n, clears;
    row_type rows[7];
    assign hready = hreadyout;
    serial_register_write_slave #(.MS_CYCLES(10)) uut (.core_clk(core_clk), .reset_n(reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rxIn(rxIn), .txOut(txOut), .txReady(txReady), .motorCmd(motorCmd));
    serial_master_model partner (.core_clk(core_clk), .rxIn(rxIn), .txOut(txOut),
        .txReady(txReady));
    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // A hang anywhere ends the run as a failure.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results();
        end
    end
    // Fault clear stands for one cycle only, so every pulse is counted as it passes.
    always @(posedge core_clk) begin
        if (motorCmd.faultClear === 1'b1) begin
            clears++;
        end
    end
    task results;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    // One single AHB-Lite transfer; read data lands in rd.
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'b10; hsize <= 3'b010;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // Reference CRC, kept independent of the design.
    task crcAdd;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
    endtask : crcAdd
    task frame(input int r);
        q.delete();
        for (int i = rows[r].len - 1; i >= 0; i--) q.push_back(rows[r].p[8*i +: 8]);
        crcAdd();
        partner.replyQ.delete();
    endtask : frame
    // Rows: payload, then run/brakeStop/direction and speed once the frame has acted.
    initial begin
        {reset_n, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        rows[0] = '{27, 216'h01_1013_4000_0A14_0000_07D0_0000_0064_0000_000A_0000_0005_0000_0038,
            6'h28, 32'h0000_07D0};
        rows[1] = '{6, 216'h0106_1349_0030, 6'h08, 32'h0000_07D0};
        rows[2] = '{6, 216'h0106_007D_0038, 6'h28, 32'h0000_07D0};
        rows[3] = '{6, 216'h0106_1341_0000, 6'h08, 32'h0000_0000};
        rows[4] = '{6, 216'h0106_1341_0BB8, 6'h28, 32'h0000_0BB8};
        rows[5] = '{6, 216'h0106_007D_00BD, 6'h2D, 32'h0000_0BB8};
        rows[6] = '{6, 216'h0106_007D_0028, 6'h18, 32'h0000_0BB8};
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        `CHK(rd, 32'h0000_0101)
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        `CHK(rd, 32'h0000_0478)
        // Short character time and a one-tick reply wait (10 cycles with MS_CYCLES at 10) keep frames quick.
        ahb(1'b1, 32'h0000_0004, 32'h0001_0004);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        `CHK(rd, 32'h0001_0004)
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
        `CHK(rd[12:7], 6'h01)
        `CHK(hresp, 1'b0)
        for (int r = 0; r < 7; r++) begin
            frame(r);
            partner.sendFrame(q);
            n = 0;
            while (txOut.valid !== 1'b1 && n < 500) begin
                @(posedge core_clk);
                n++;
            end
            `CHK(n >= 22 && n < 500, 1'b1)
            if (q[1] == 8'h10) begin
                q = q[0:5];
                crcAdd();
            end
            n = 0;
            while (partner.replyQ.size() < 8 && n < 500) begin
                @(posedge core_clk);
                n++;
            end
            for (int i = 0; i < 8; i++) `CHK(partner.replyQ[i], q[i])
            `CHK({motorCmd.run, motorCmd.brakeStop, motorCmd.direction, motorCmd.dataSelect},
                rows[r].rbd)
            `CHK(motorCmd.speed, rows[r].spd)
        end
        `CHK(clears, 1)
        `CHK(motorCmd.torqueLimit, 32'h0000_0064)
        `CHK(motorCmd.accelTime, 32'h0000_000A)
        `CHK(motorCmd.decelTime, 32'h0000_0005)
        // With immediate update off a new speed waits for a run edge; no reply wait either.
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        ahb(1'b1, 32'h0000_0004, 32'h0000_0004);
        rows[0] = '{6, 216'h0106_1341_0FA0, 6'h18, 32'h0000_0BB8};
        frame(0);
        partner.sendFrame(q);
        repeat (200) @(posedge core_clk);
        `CHK(partner.replyQ.size(), 8)
        `CHK(motorCmd.speed, rows[0].spd)
        // A corrupted check word must be dropped with no reply and no effect.
        frame(2);
        q[7] = q[7] ^ 8'h01;
        partner.sendFrame(q);
        repeat (200) @(posedge core_clk);
        `CHK(partner.replyQ.size(), 0)
        `CHK(motorCmd.brakeStop, 1'b1)
        // A mid-run reset restores defaults; brake release then reads clear, so the drive stops.
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK({motorCmd.run, motorCmd.brakeStop, motorCmd.speed}, {2'h1, 32'h0000_0000})
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        `CHK(rd, 32'h0000_0478)
        results();
    end
endmodule : serial_register_write_slave_tb_top
`default_nettype wire
